// file: core/bus_timeout_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          bus time-out watchdog.
// Assumes: 32-bit APB data, one register per aligned word.
// Notes:   Definitions only.
`ifndef BUS_TIMEOUT_DEFINES_SVH
`define BUS_TIMEOUT_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define TOUT_CTRL_OFF 12'h000
`define TOUT_IRQ_STATUS_OFF 12'h004
`define TOUT_IRQ_MASK_OFF 12'h008
`define TOUT_STATE_OFF 12'h00C

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define TOUT_ENABLE_BIT 7
`define TOUT_FLAG_BIT 6
`define TOUT_SEL_MSB 5
`define TOUT_SEL_LSB 0
`define TOUT_CTRL_RESET 8'h00

// Interrupt status and mask bit positions
`define TOUT_IRQ_TIMEOUT_BIT 0
`define TOUT_IRQ_MATCH_BIT 1
`define TOUT_IRQ_RESET 2'h0

// ************************************************************
// Timing counts
// ************************************************************
`define TOUT_SUB_DIVIDE 32
`define TOUT_PERIOD_CHOICES 64

`endif

// file: core/bus_timeout_pkg.sv
// Purpose: Types shared by the bus time-out watchdog.
// Assumes: Constants live in bus_timeout_defines.svh.
// Notes:   States are Gray coded along idle, armed, counting.
package bus_timeout_pkg;

    typedef enum logic [1:0]
    {
        WATCH_IDLE = 2'b00,
        WATCH_ARMED = 2'b01,
        WATCH_COUNTING = 2'b11
    } watch_state_type;

endpackage : bus_timeout_pkg

// file: core/i2c_slave_bus_timeout.sv
// Purpose: Time-out watchdog beside an I2C slave interface, with APB
//          registers and a level interrupt.
// Assumes: scl_in/sda_in come from the pads; address_match_pulse comes
//          from the slave core; sub_clock_tick is one pclk pulse per
//          subsystem clock period.
// Notes:   On time-out core_reset_pulse resets the slave state machine
//          and control register one in the core.
// Functional notes
// - Counting starts on START followed by own address match.
// - Every SCL falling edge clears the running count to zero.
// - Time-out when elapsed time exceeds the programmed period.
// - A STOP condition stops counting.
// - On overflow: counter halts, enable clears, flag sets.
// - A time-out raises the shared I2C interrupt.
// - Time-out resets slave state machine and control register one only.
// - Software clears the flag by writing; otherwise it stays set.
// - Six-bit select: period is (select+1) times 32 subsystem clocks.
// - Counter advances once per subsystem clock divided by 32.
// - Bit 7 enables the time-out function.
// - Bit 6 is the time-out flag.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "bus_timeout_defines.svh"

module i2c_slave_bus_timeout #(
    parameter int SUB_DIVIDE = `TOUT_SUB_DIVIDE
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic address_match_pulse,
    input wire logic sub_clock_tick,
    output logic core_reset_pulse,
    output logic irq
);

    localparam int DIV_W = $clog2(SUB_DIVIDE);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SUB_DIVIDE - 1);

    // ************************************************************
    // Pin synchronisers and bus condition detection
    // ************************************************************
    logic scl_meta_q;
    logic scl_sync_q;
    logic scl_prev_q;
    logic sda_meta_q;
    logic sda_sync_q;
    logic sda_prev_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_meta_q <= scl_in;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
            sda_meta_q <= sda_in;
            sda_sync_q <= sda_meta_q;
            sda_prev_q <= sda_sync_q;
        end
    end

    // Only the second stage and its delayed copy feed any gate
    wire scl_fall = scl_prev_q & ~scl_sync_q;
    wire scl_held_high = scl_prev_q & scl_sync_q;
    wire start_seen = scl_held_high & sda_prev_q & ~sda_sync_q;
    wire stop_seen = scl_held_high & ~sda_prev_q & sda_sync_q;

    // ************************************************************
    // APB decode
    // ************************************************************
    logic [7:0] ctrl_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable;
    wire hit_ctrl = paddr == `TOUT_CTRL_OFF;
    wire hit_status = paddr == `TOUT_IRQ_STATUS_OFF;
    wire hit_mask = paddr == `TOUT_IRQ_MASK_OFF;
    wire hit_state = paddr == `TOUT_STATE_OFF;
    wire addr_mapped = hit_ctrl | hit_status | hit_mask | hit_state;
    wire wr_ctrl = access_done & pwrite & hit_ctrl;
    wire wr_status = access_done & pwrite & hit_status;
    wire wr_mask = access_done & pwrite & hit_mask;

    wire enable_bit = ctrl_q[`TOUT_ENABLE_BIT];
    wire [5:0] period_sel = ctrl_q[`TOUT_SEL_MSB:`TOUT_SEL_LSB];

    // ************************************************************
    // Watchdog state and counter
    // ************************************************************
    bus_timeout_pkg::watch_state_type state_q;
    bus_timeout_pkg::watch_state_type state_d;
    logic [DIV_W-1:0] div_q;
    logic [6:0] count_q;
    logic timeout_pulse_q;

    wire counting = state_q == bus_timeout_pkg::WATCH_COUNTING;
    // Divided tick restarts at each SCL fall so every interval is whole
    wire div_tick = sub_clock_tick & (div_q == DIV_LAST);
    wire period_hit = counting & div_tick & ~scl_fall &
        (count_q == {1'b0, period_sel});
    wire timeout_event = period_hit & enable_bit;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            bus_timeout_pkg::WATCH_IDLE:
                if (start_seen)
                    state_d = bus_timeout_pkg::WATCH_ARMED;
            bus_timeout_pkg::WATCH_ARMED:
                if (stop_seen)
                    state_d = bus_timeout_pkg::WATCH_IDLE;
                else if (address_match_pulse)
                    state_d = bus_timeout_pkg::WATCH_COUNTING;
            bus_timeout_pkg::WATCH_COUNTING:
                if (stop_seen || timeout_event)
                    state_d = bus_timeout_pkg::WATCH_IDLE;
                else if (start_seen)
                    state_d = bus_timeout_pkg::WATCH_ARMED;
            default:
                state_d = bus_timeout_pkg::WATCH_IDLE;
        endcase
        if (!enable_bit)
            state_d = bus_timeout_pkg::WATCH_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= bus_timeout_pkg::WATCH_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= '0;
            count_q <= 7'h00;
        end
        else if (!counting || scl_fall)
        begin
            div_q <= '0;
            count_q <= 7'h00;
        end
        else if (sub_clock_tick)
        begin
            div_q <= div_tick ? '0 : div_q + 1'b1;
            if (div_tick)
                count_q <= count_q + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timeout_pulse_q <= 1'b0;
        else
            timeout_pulse_q <= timeout_event;
    end

    assign core_reset_pulse = timeout_pulse_q;

    // ************************************************************
    // Registers
    // ************************************************************
    // Hardware set of the flag wins over a software write of zero
    wire [7:0] ctrl_wr = wr_ctrl ? pwdata[7:0] : ctrl_q;
    wire [7:0] ctrl_d = timeout_event ?
        {1'b0, 1'b1, ctrl_wr[5:0]} : ctrl_wr;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `TOUT_CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    wire [1:0] irq_events = {address_match_pulse, timeout_event};
    wire [1:0] status_clear = wr_status ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_q <= `TOUT_IRQ_RESET;
            irq_mask_q <= `TOUT_IRQ_RESET;
        end
        else
        begin
            irq_status_q <= (irq_status_q & ~status_clear) | irq_events;
            if (wr_mask)
                irq_mask_q <= pwdata[1:0];
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    wire [31:0] read_mux =
        hit_ctrl ? {24'h000000, ctrl_q} :
        hit_status ? {30'h00000000, irq_status_q} :
        hit_mask ? {30'h00000000, irq_mask_q} :
        hit_state ? {16'h0000, 1'b0, count_q, 6'h00, state_q} :
        32'h00000000;

    // Read data is captured in setup so the answer comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_q <= pwrite ? 32'h00000000 : read_mux;
            pslverr_q <= ~addr_mapped;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q & access_done;
    assign pready = 1'b1;

    // ************************************************************
    // Assertions
    // ************************************************************
    start_count_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == bus_timeout_pkg::WATCH_ARMED && address_match_pulse &&
        !stop_seen && enable_bit |=> counting)
        else $error("Counting did not start after address match");

    arm_on_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == bus_timeout_pkg::WATCH_IDLE && start_seen && enable_bit
        |=> state_q == bus_timeout_pkg::WATCH_ARMED)
        else $error("START did not arm the watchdog");

    fall_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        scl_fall |=> count_q == 7'h00 && div_q == '0)
        else $error("SCL fall did not clear the count");

    expire_point_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_reset_pulse |-> $past(count_q) == {1'b0, $past(period_sel)}
        && $past(div_q) == DIV_LAST)
        else $error("Time-out fired at the wrong count");

    stop_halts_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        counting && stop_seen |=> !counting ##1 count_q == 7'h00)
        else $error("STOP did not stop counting");

    count_held_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !counting |=> count_q == 7'h00 && div_q == '0)
        else $error("Count moved while not counting");

    overflow_side_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        timeout_event |=> !ctrl_q[`TOUT_ENABLE_BIT] &&
        ctrl_q[`TOUT_FLAG_BIT] && !counting)
        else $error("Overflow did not halt, disable and flag");

    timeout_irq_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        timeout_event && irq_mask_q[`TOUT_IRQ_TIMEOUT_BIT] |=> irq)
        else $error("Time-out raised no interrupt");

    timeout_status_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_reset_pulse |-> irq_status_q[`TOUT_IRQ_TIMEOUT_BIT])
        else $error("Time-out left no status bit");

    reset_once_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_reset_pulse |=> !core_reset_pulse)
        else $error("Core reset lasted more than one cycle");

    reset_to_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_reset_pulse |-> state_q == bus_timeout_pkg::WATCH_IDLE)
        else $error("Watch state not idle after time-out");

    flag_sticky_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[`TOUT_FLAG_BIT] && !wr_ctrl |=> ctrl_q[`TOUT_FLAG_BIT])
        else $error("Flag cleared without a write");

    select_kept_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        timeout_event && !wr_ctrl |=> period_sel == $past(period_sel))
        else $error("Period select lost on time-out");

    tick_spacing_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        counting && count_q == 7'h00 && !scl_fall ##1 count_q == 7'h01 |->
        $past(div_tick))
        else $error("Count advanced without a divided tick");

    count_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        counting && div_tick && !scl_fall && !timeout_event |=>
        count_q == $past(count_q) + 7'h01)
        else $error("Divided tick did not advance the count");

    write_lands_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && !timeout_event |=> ctrl_q == $past(pwdata[7:0]))
        else $error("Control write did not land");

    quiet_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enable_bit |-> !timeout_event ##1 !counting)
        else $error("Watchdog active while disabled");

    disabled_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enable_bit |=> state_q == bus_timeout_pkg::WATCH_IDLE)
        else $error("Watch state left idle while disabled");

endmodule : i2c_slave_bus_timeout

// file: tb/i2c_master_model.sv
// Purpose: Behavioural I2C bus master that drives SCL and SDA levels.
// Assumes: Each bus step lasts four pclk cycles, enough for the
//          double-flop synchronisers inside the watchdog.
// Notes:   SCL stands still between frames; both lines idle high.
`timescale 1ns/1ps

// ************************************************************
// Bus master model
// ************************************************************
module i2c_master_model
(
    input wire logic pclk,
    output logic scl,
    output logic sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task step(input logic c, input logic d);
        repeat (4) @(posedge pclk);
        scl <= c;
        sda <= d;
    endtask : step

    // SDA falls while SCL stays high, then SCL drops for the first bit
    task start_cond();
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start_cond

    // SDA rises while SCL is high
    task stop_cond();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop_cond

    // One bit clock: data held steady while SCL is high
    task clock_fall();
        step(1'b1, sda);
        step(1'b0, sda);
    endtask : clock_fall
endmodule : i2c_master_model

// file: tb/i2c_slave_bus_timeout_tb.sv
// Purpose: Self-checking bench of the bus time-out watchdog.
// Assumes: SUB_DIVIDE shortened to 4; subsystem tick every 2nd cycle.
// Notes:   Time-out window allows a few cycles of pin sync delay.
`timescale 1ns/1ps
`include "bus_timeout_defines.svh"

// ************************************************************
// Bench top
// ************************************************************
module i2c_slave_bus_timeout_tb;
    localparam int DIV = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl;
    logic sda;
    logic amp = 1'b0;
    logic sub_tick = 1'b0;
    logic core_reset_pulse;
    logic irq;
    logic [31:0] seed = 32'h7ACF9533;
    logic [31:0] rd;
    logic err;
    logic [5:0] sel;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int pulses = 0;
    int el;
    int p0;

    i2c_slave_bus_timeout #(.SUB_DIVIDE(DIV)) i_i2c_slave_bus_timeout (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
        .address_match_pulse(amp), .sub_clock_tick(sub_tick),
        .core_reset_pulse(core_reset_pulse), .irq(irq));

    i2c_master_model master (.pclk(pclk), .scl(scl), .sda(sda));

    initial forever #20 pclk = ~pclk;

    always @(posedge pclk)
    begin
        sub_tick <= ~sub_tick;
        cycles <= cycles + 1;
        if (core_reset_pulse === 1'b1)
            pulses <= pulses + 1;
        if (cycles == 30000)
        begin
            errors = errors + 1;
            wrap_up();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Cycles of one period: (select+1) divided ticks of DIV sub ticks
    function automatic int period(input logic [5:0] s);
        return (int'(s) + 1) * DIV * 2;
    endfunction : period

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task match();
        @(posedge pclk);
        amp <= 1'b1;
        @(posedge pclk);
        amp <= 1'b0;
    endtask : match

    task wrap_up();
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `TOUT_CTRL_OFF, 0);
        chk("ctrl reset", rd, 32'h0);
        apb(0, `TOUT_IRQ_MASK_OFF, 0);
        chk("mask reset", rd, 32'h0);
        apb(0, 12'h010, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        rd = xs() & 32'h7F;
        p0 = rd;
        apb(1, `TOUT_CTRL_OFF, p0);
        apb(0, `TOUT_CTRL_OFF, 0);
        chk("ctrl rw", rd, p0);
        for (int i = 0; i < 3; i++)
        begin
            // Last pass takes the longest period as a corner case
            sel = (i == 2) ? 6'h3F : 6'(2 + xs() % 4);
            apb(1, `TOUT_IRQ_MASK_OFF, {31'h0, i == 0});
            apb(1, `TOUT_CTRL_OFF, {24'h0, 2'b10, sel});
            p0 = pulses;
            master.start_cond();
            match();
            el = 0;
            while (core_reset_pulse !== 1'b1 && el < 600)
            begin
                @(negedge pclk);
                el++;
            end
            el = el - period(sel);
            chk("period", el > 0 && el <= 4, 1);
            @(negedge pclk);
            chk("one reset", pulses - p0, 1);
            chk("irq on", irq, i == 0);
            apb(0, `TOUT_CTRL_OFF, 0);
            chk("ctrl after", rd, {24'h0, 2'b01, sel});
            apb(0, `TOUT_IRQ_STATUS_OFF, 0);
            chk("sources", rd, 32'h3);
            apb(1, `TOUT_IRQ_STATUS_OFF, 32'h3);
            @(negedge pclk);
            chk("irq off", irq, 0);
            apb(0, `TOUT_CTRL_OFF, 0);
            chk("flag sticky", rd[6], 1);
            apb(1, `TOUT_CTRL_OFF, {26'h0, sel});
            apb(0, `TOUT_CTRL_OFF, 0);
            chk("flag clear", rd, {26'h0, sel});
        end
        apb(1, `TOUT_CTRL_OFF, 32'h83);
        master.start_cond();
        match();
        p0 = pulses;
        repeat (6) master.clock_fall();
        chk("falls clear", pulses, p0);
        apb(0, `TOUT_STATE_OFF, 0);
        chk("counting", rd[1:0], 2'b11);
        master.stop_cond();
        repeat (3 * period(3)) @(posedge pclk);
        chk("stop halts", pulses, p0);
        apb(0, `TOUT_STATE_OFF, 0);
        chk("idle", rd[1:0], 2'b00);
        apb(1, `TOUT_CTRL_OFF, 32'h00);
        master.start_cond();
        match();
        repeat (100) @(posedge pclk);
        chk("disabled", pulses, p0);
        apb(0, `TOUT_STATE_OFF, 0);
        chk("stays idle", rd[1:0], 2'b00);
        master.stop_cond();
        wrap_up();
    end
endmodule : i2c_slave_bus_timeout_tb
